// file: inc/bcg_pkg.sv
package bcg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus states: idle, two status phases, two command phases
  typedef enum logic [2:0] {
    bcg_idle,
    bcg_stat1,
    bcg_stat2,
    bcg_cmd1,
    bcg_cmd2
  } bcg_state_e;

  // command outputs, active high inside the block
  typedef struct packed {
    logic intr_ack;
    logic io_read;
    logic io_write;
    logic mem_read;
    logic mem_write;
  } bcg_cmd_s;

  // processor status inputs, status bits active low
  typedef struct packed {
    logic mem_not_io;
    logic cycle_status_high_bit;
    logic cycle_status_low_bit;
  } bcg_status_s;

  ////////////////////////////////////////////////////////////////////////////
  // cycle codes {mem_not_io, high bit, low bit}
  localparam logic [2:0] CODE_INTR_ACK = 3'h0;
  localparam logic [2:0] CODE_IO_READ = 3'h1;
  localparam logic [2:0] CODE_IO_WRITE = 3'h2;
  localparam logic [2:0] CODE_HALT = 3'h4;
  localparam logic [2:0] CODE_MEM_READ = 3'h5;
  localparam logic [2:0] CODE_MEM_WRITE = 3'h6;
  localparam logic [2:0] STATUS_INACTIVE = 3'h7;

  // timing counts in clock edges
  localparam logic [1:0] GRANT_EDGES = 2'h3;
  localparam logic [1:0] MODE_CYCLES = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 12'h000;
  localparam logic [ADDR_W-1:0] REG_STATE = 12'h004;
  // control fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // state fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_SELECT_BIT = 4;
  localparam int ST_DELAY_BIT = 5;
  localparam int ST_MODE_BIT = 6;
  localparam int ST_DEN_BIT = 7;
  localparam int ST_DIR_BIT = 8;
  localparam int ST_CMD_LSB = 12;

endpackage

// file: rtl/bcg_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage input synchroniser; output follows once stage two and three agree
module bcg_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // raw and filtered data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1; // metastability stage, read only by s2
  logic [W-1:0] s2; // second stage
  logic [W-1:0] s3; // third stage
  logic [W-1:0] agree; // bits where stage two and three match

  assign agree = ~(s2 ^ s3);

  // shift chain and agreement filter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      dout <= INIT;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= (s3 & agree) | (dout & ~agree);
    end
  end

endmodule // bcg_sync
`default_nettype wire

// file: rtl/bcg_top.sv
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Function
// RQ1 - select sampled high at status end enables outputs
// RQ2 - deselected: no commands, no enable, direction high
// RQ3 - deselected: ignore delay, enable, ready until restart
// RQ4 - select sample held for whole cycle
// RQ5 - local write: enable in second status phase
// RQ6 - deselected write: enable forced low in command
// RQ7 - grant withdrawn: float commands, enable off
// RQ8 - arbiter withdraws grant only in idle/status
// RQ9 - grant given: enable follows cycle at once
// RQ10 - commands wait three edges after grant
// RQ11 - command enable low: commands and enable off
// RQ12 - command enable high: restore cycle levels
// RQ13 - system still ends cycle with ready
// RQ14 - command only after delay sampled low
// RQ15 - delay never touches latch, cascade, enable, direction
// RQ16 - delay sampled at status end, then each edge
// RQ17 - local: command at once; shared: normal time
// RQ18 - ready before delay clears: no command issued
// RQ19 - mode falling: two cycles before command
// RQ20 - status and command states last two cycles
// RQ21 - ready sampled each command end, wait states
// RQ22 - shared timing needs at least one wait
module bcg_top
  import bcg_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor status and cycle control pins
  input wire bcg_status_s status_in,
  input wire logic bus_select_latched_enable,
  input wire logic command_enable_or_grant,
  input wire logic command_delay_input,
  input wire logic shared_bus_timing_select,
  input wire logic ready_n,
  // command outputs and their drive enable
  output bcg_cmd_s cmd_out,
  output logic cmd_oe,
  // control outputs
  output logic addr_latch_enable,
  output logic cascade_address_enable,
  output logic transceiver_enable,
  output logic transceiver_direction
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta; // first reset stage
  logic rst_n; // released reset used everywhere else

  // two-flop release of the asynchronous reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int PIN_W = 8;
  localparam logic [PIN_W-1:0] PIN_INIT = {STATUS_INACTIVE, 5'h19};
  logic [PIN_W-1:0] pin_raw; // packed raw pins
  logic [PIN_W-1:0] pin_s; // filtered pins
  logic [2:0] status_code; // filtered status code
  logic select_s; // filtered bus select
  logic cen_aen_s; // filtered shared enable/grant pin
  logic delay_s; // filtered command delay
  logic mode_s; // filtered timing mode select
  logic ready_n_s; // filtered ready

  assign pin_raw = {status_in, bus_select_latched_enable,
    command_enable_or_grant, command_delay_input,
    shared_bus_timing_select, ready_n};

  bcg_sync #(
    .W(PIN_W),
    .INIT(PIN_INIT)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(pin_raw),
    .dout(pin_s)
  );

  assign status_code = pin_s[7:5];
  assign select_s = pin_s[4];
  assign cen_aen_s = pin_s[3];
  assign delay_s = pin_s[2];
  assign mode_s = pin_s[1];
  assign ready_n_s = pin_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // apb register file
  logic [31:0] control; // software control word
  logic [31:0] state_word; // live status word
  logic hit_control; // address matches control
  logic hit_state; // address matches state
  logic unmapped; // address matches nothing
  logic wr_access; // write completes this edge
  logic setup_phase; // first cycle of a transfer
  logic block_enable; // software allows new cycles

  assign hit_control = (paddr == REG_CONTROL);
  assign hit_state = (paddr == REG_STATE);
  assign unmapped = !(hit_control || hit_state);
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign pready = psel && penable;
  assign pslverr = psel && penable && unmapped;
  assign block_enable = control[CTRL_ENABLE_BIT];

  // control register write, read data captured in setup phase
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      control <= CTRL_RESET;
      prdata <= 32'h0000_0000;
    end else begin
      if (wr_access && hit_control) begin
        control <= pwdata;
      end
      if (setup_phase) begin
        prdata <= hit_control ? control : (hit_state ? state_word : '0);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle decode
  bcg_state_e state; // current bus state
  bcg_state_e next_state; // next bus state
  logic [2:0] cyc_code; // code latched at cycle start
  logic start; // either status bit low starts a cycle while the control enable bit is set
  logic is_halt; // halt cycle activates nothing
  logic is_write; // write cycle
  logic is_read; // read or acknowledge cycle
  logic in_status; // either status phase
  logic in_cmd; // either command phase
  logic cycle_end; // ready ends a selected cycle
  logic selected; // select sample held for the cycle

  assign start = block_enable && (status_code[1:0] != STATUS_INACTIVE[1:0]);
  assign is_halt = (cyc_code == CODE_HALT);
  assign is_write = (cyc_code == CODE_IO_WRITE) || (cyc_code == CODE_MEM_WRITE);
  assign is_read = (cyc_code == CODE_INTR_ACK) || (cyc_code == CODE_IO_READ) ||
    (cyc_code == CODE_MEM_READ);
  assign in_status = (state == bcg_stat1) || (state == bcg_stat2);
  assign in_cmd = (state == bcg_cmd1) || (state == bcg_cmd2);
  assign cycle_end = (state == bcg_cmd2) && selected && !ready_n_s; // [RQ21]

  // bus state sequence
  always_comb begin
    next_state = state;
    case (state)
      bcg_idle: begin
        if (start) begin
          next_state = bcg_stat1;
        end
      end
      bcg_stat1: begin
        next_state = bcg_stat2; // [RQ20]
      end
      bcg_stat2: begin
        // halt ignores every control input until a new start
        next_state = is_halt ? bcg_idle : bcg_cmd1;
      end
      bcg_cmd1: begin
        next_state = bcg_cmd2; // [RQ20]
      end
      bcg_cmd2: begin
        if (!selected) begin
          // ready is not looked at while deselected
          next_state = start ? bcg_stat1 : bcg_cmd1; // [RQ3]
        end else if (cycle_end) begin
          next_state = start ? bcg_stat1 : bcg_idle; // [RQ21]
        end else begin
          next_state = bcg_cmd1; // wait state [RQ21]
        end
      end
      default: begin
        next_state = bcg_idle;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-cycle qualifiers
  logic delay_done; // command delay seen low
  logic late_ok; // shared timing command time reached
  logic new_cycle; // entering first status phase
  logic sel_edge; // end of the status state
  logic delay_sample; // delay sampling edge

  assign new_cycle = (next_state == bcg_stat1) && (state != bcg_stat1);
  assign sel_edge = (state == bcg_stat2);
  assign delay_sample = (sel_edge && !is_halt) || (in_cmd && selected);

  // cycle code, select hold, delay and shared-timing flags
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= bcg_idle;
      cyc_code <= STATUS_INACTIVE;
      selected <= 1'b0;
      delay_done <= 1'b0;
      late_ok <= 1'b0;
    end else begin
      state <= next_state;
      if (new_cycle) begin
        cyc_code <= status_code;
        selected <= 1'b0;
        delay_done <= 1'b0;
        late_ok <= 1'b0;
      end else begin
        if (sel_edge) begin
          selected <= select_s; // [RQ1] [RQ4]
        end
        if (delay_sample && !delay_done && !delay_s) begin
          delay_done <= 1'b1; // [RQ16]
        end
        if (state == bcg_cmd1) begin
          late_ok <= 1'b1; // [RQ17]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // grant and mode timers
  logic [1:0] grant_cnt; // edges since grant went low
  logic [1:0] mode_cnt; // cycles since mode fell
  logic mode_prev; // mode value one cycle back
  logic grant_withdrawn; // shared timing and grant pin high
  logic grant_ok; // three edges after grant
  logic mode_ok; // two cycles after mode fell

  assign grant_withdrawn = mode_s && cen_aen_s;
  assign grant_ok = (grant_cnt == GRANT_EDGES);
  assign mode_ok = (mode_cnt == MODE_CYCLES);

  // saturating counters for grant and mode change
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      grant_cnt <= 2'h0;
      mode_cnt <= MODE_CYCLES;
      mode_prev <= 1'b0;
    end else begin
      mode_prev <= mode_s;
      if (grant_withdrawn) begin
        grant_cnt <= 2'h0;
      end else if (!grant_ok) begin
        grant_cnt <= grant_cnt + 2'h1; // [RQ10]
      end
      if (mode_prev && !mode_s) begin
        mode_cnt <= 2'h0;
      end else if (!mode_ok) begin
        mode_cnt <= mode_cnt + 2'h1; // [RQ19]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output levels
  logic gate; // enable/grant qualification for this mode
  logic cmd_timing; // mode specific command timing met
  logic cmd_live; // command may be active now
  logic next_den; // next transceiver enable
  logic next_dir; // next transceiver direction
  logic next_ale; // next address latch enable
  logic next_mce; // next cascade enable
  logic next_oe; // next command drive enable
  bcg_cmd_s next_cmd; // next command outputs

  // mode 0 uses the pin as command enable, mode 1 as grant
  assign gate = mode_s ? !cen_aen_s : cen_aen_s; // [RQ7] [RQ9] [RQ11] [RQ12]
  assign cmd_timing = mode_s ? (late_ok && grant_ok) : mode_ok; // [RQ17] [RQ19]
  assign cmd_live = in_cmd && selected && !is_halt && delay_done && // [RQ14]
    cmd_timing && gate; // [RQ1] [RQ2]
  // delay flag is kept out of the control outputs [RQ15]
  assign next_den = gate && !is_halt && (
    (in_cmd && selected) || // [RQ6] [RQ2]
    (!mode_s && is_write && (state == bcg_stat2))); // [RQ5]
  assign next_dir = !(is_read && in_cmd && selected); // [RQ2] [RQ18]
  assign next_ale = (state == bcg_stat1) && !is_halt;
  assign next_mce = in_status && (cyc_code == CODE_INTR_ACK);
  assign next_oe = !grant_withdrawn; // [RQ7]
  assign next_cmd.intr_ack = cmd_live && (cyc_code == CODE_INTR_ACK);
  assign next_cmd.io_read = cmd_live && (cyc_code == CODE_IO_READ);
  assign next_cmd.io_write = cmd_live && (cyc_code == CODE_IO_WRITE);
  assign next_cmd.mem_read = cmd_live && (cyc_code == CODE_MEM_READ);
  assign next_cmd.mem_write = cmd_live && (cyc_code == CODE_MEM_WRITE);

  // registered outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_out <= '0;
      cmd_oe <= 1'b1;
      addr_latch_enable <= 1'b0;
      cascade_address_enable <= 1'b0;
      transceiver_enable <= 1'b0;
      transceiver_direction <= 1'b1;
    end else begin
      cmd_out <= next_cmd; // [RQ18]
      cmd_oe <= next_oe;
      addr_latch_enable <= next_ale;
      cascade_address_enable <= next_mce;
      transceiver_enable <= next_den;
      transceiver_direction <= next_dir;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state word for software
  always_comb begin
    state_word = '0;
    state_word[ST_STATE_LSB +: 3] = state;
    state_word[ST_SELECT_BIT] = selected;
    state_word[ST_DELAY_BIT] = delay_done;
    state_word[ST_MODE_BIT] = mode_s;
    state_word[ST_DEN_BIT] = transceiver_enable;
    state_word[ST_DIR_BIT] = transceiver_direction;
    state_word[ST_CMD_LSB +: 5] = cmd_out;
  end

endmodule // bcg_top
`default_nettype wire

// file: test/bcg_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// status source, decoder, arbiter and ready source
module bcg_cpu_model
  import bcg_pkg::*;
(
  // clock
  input wire logic mclk,
  // pins toward the controller
  output bcg_status_s status_in,
  output logic sel,
  output logic gate,
  output logic dly,
  output logic mode,
  output logic ready_n
);
  // idle levels at time zero
  initial begin
    status_in = STATUS_INACTIVE;
    sel = 1'b1;
    gate = 1'b1;
    dly = 1'b0;
    mode = 1'b0;
    ready_n = 1'b1;
  end
  // one bus cycle: code, select, delay, gate, mode, wait states
  task automatic run(input logic [2:0] c, input logic s, d, g, m,
                     input int w);
    @(posedge mclk);
    mode <= m;
    gate <= m ? !g : g; // grant moves only while idle
    repeat (8) @(posedge mclk);
    status_in <= c;
    sel <= s;
    dly <= d;
    repeat (2) @(posedge mclk);
    status_in <= STATUS_INACTIVE;
    repeat (2 + 2 * w) @(posedge mclk);
    ready_n <= 1'b0; // ready pulsed low every cycle, ends selected ones
    repeat (2) @(posedge mclk);
    ready_n <= 1'b1;
    repeat (6) @(posedge mclk);
    dly <= 1'b0;
  endtask
endmodule // bcg_cpu_model
`default_nettype wire

// file: test/bcg_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
// checker on the top module pins
module bcg_top_properties
  import bcg_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // control pins watched
  input wire logic command_enable_or_grant,
  input wire logic shared_bus_timing_select,
  // outputs watched
  input wire bcg_cmd_s cmd_out,
  input wire logic cmd_oe,
  input wire logic addr_latch_enable,
  input wire logic transceiver_enable,
  input wire logic transceiver_direction
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  // read and write command groups
  wire rd_cmd = cmd_out.intr_ack | cmd_out.io_read | cmd_out.mem_read;
  wire wr_cmd = cmd_out.io_write | cmd_out.mem_write;
  wire any_cmd = |cmd_out;
  // local mode with command enable low
  wire lcl_off = !shared_bus_timing_select && !command_enable_or_grant;
  // shared mode with grant withdrawn
  wire gnt_off = shared_bus_timing_select && command_enable_or_grant;
  ////////////////////////////////////////////////////////////////////////////
  a_one_cmd: assert property ($onehot0(cmd_out))
    else $error("two commands at once");
  a_cmd_enable: assert property (any_cmd |-> transceiver_enable)
    else $error("command without transceiver enable");
  a_cmd_driven: assert property (any_cmd |-> cmd_oe)
    else $error("command while floating");
  a_read_dir: assert property (rd_cmd |-> !transceiver_direction)
    else $error("read command with direction high");
  a_write_dir: assert property (wr_cmd |-> transceiver_direction)
    else $error("write command with direction low");
  a_latch_pulse: assert property (
    $rose(addr_latch_enable) |=> !addr_latch_enable)
    else $error("latch strobe too long");
  a_local_drive: assert property (
    (!shared_bus_timing_select)[*8] |-> cmd_oe)
    else $error("commands float in local mode");
  a_grant_float: assert property (
    gnt_off[*8] |-> !cmd_oe && !transceiver_enable)
    else $error("drive kept after grant withdrawn");
  a_enable_off: assert property (
    lcl_off[*8] |-> !any_cmd && !transceiver_enable)
    else $error("outputs active with command enable low");
  // main scenarios
  c_float: cover property (!cmd_oe);
  c_shared_cmd: cover property (shared_bus_timing_select && any_cmd);
  c_gated: cover property (lcl_off[*8]);
endmodule // bcg_top_properties
bind bcg_top bcg_top_properties u_props (
  .mclk(mclk),
  .arst_n(arst_n),
  .command_enable_or_grant(command_enable_or_grant),
  .shared_bus_timing_select(shared_bus_timing_select),
  .cmd_out(cmd_out),
  .cmd_oe(cmd_oe),
  .addr_latch_enable(addr_latch_enable),
  .transceiver_enable(transceiver_enable),
  .transceiver_direction(transceiver_direction)
);
`default_nettype wire

// file: test/bus_command_gating_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bus_command_gating_control_tb_top
  import bcg_pkg::*;
;
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sel, gate, dly, mode, ready_n, cmd_oe, latch, casc, t_en, t_dir;
  logic s, d, g, m, wr, act, er, mon;
  logic [2:0] c;
  bcg_status_s st;
  bcg_cmd_s cmd_out, seen_cmd;
  logic seen_ten, seen_rd, seen_ale, seen_cas, seen_flt;
  int error_cnt, cmp_count, seed, cycles, w;
  logic [2:0] codes [6] = '{CODE_INTR_ACK, CODE_IO_READ, CODE_IO_WRITE,
                            CODE_HALT, CODE_MEM_READ, CODE_MEM_WRITE};
  // {select, delay stuck, gate open, shared mode}
  logic [3:0] cfg [6] = '{4'ha, 4'h2, 4'he, 4'h8, 4'hb, 4'h9};
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  bcg_top DUT (.mclk(mclk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .status_in(st),
    .bus_select_latched_enable(sel), .command_enable_or_grant(gate),
    .command_delay_input(dly), .shared_bus_timing_select(mode),
    .ready_n(ready_n), .cmd_out(cmd_out), .cmd_oe(cmd_oe),
    .addr_latch_enable(latch), .cascade_address_enable(casc),
    .transceiver_enable(t_en), .transceiver_direction(t_dir));
  bcg_cpu_model u_cpu (.mclk(mclk), .status_in(st), .sel(sel),
    .gate(gate), .dly(dly), .mode(mode), .ready_n(ready_n));
  ////////////////////////////////////////////////////////////////////////////
  // collect output levels seen in one cycle, and the hang limit
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    seen_cmd <= mon ? (seen_cmd | cmd_out) : '0;
    seen_ten <= mon & (seen_ten | t_en);
    seen_rd <= mon & (seen_rd | !t_dir);
    seen_ale <= mon & (seen_ale | latch);
    seen_cas <= mon & (seen_cas | casc);
    seen_flt <= mon & (seen_flt | !cmd_oe);
    if (cycles == 5000) begin
      error_cnt = error_cnt + 1;
      complete_run();
    end
  end
  // verdict and end of run
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic wrt, input logic [ADDR_W-1:0] a,
                     input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wrt;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // expected command for a cycle code
  function automatic bcg_cmd_s exp_cmd(input logic [2:0] k);
    bcg_cmd_s e;
    e = '0;
    case (k)
      CODE_INTR_ACK: e.intr_ack = 1'b1;
      CODE_IO_READ: e.io_read = 1'b1;
      CODE_IO_WRITE: e.io_write = 1'b1;
      CODE_MEM_READ: e.mem_read = 1'b1;
      CODE_MEM_WRITE: e.mem_write = 1'b1;
      default: e = '0;
    endcase
    return e;
  endfunction
  initial begin
    {arst_n, psel, penable, pwrite, mon} = '0;
    paddr = '0;
    pwdata = '0;
    {error_cnt, cmp_count, cycles} = '0;
    seed = 32'h0aa9;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (12) @(posedge mclk);
    // registers: reset values, read-only state, unmapped place
    apb(1'b0, REG_CONTROL, 32'h0);
    chk(rd, CTRL_RESET, "control");
    apb(1'b1, REG_STATE, 32'hffff_ffff);
    apb(1'b0, REG_STATE, 32'h0);
    chk(rd & 32'h0001_f1c7, 32'h1 << ST_DIR_BIT, "state");
    apb(1'b0, 12'h010, 32'h0);
    chk(32'(er), 32'h1, "unmapped");
    $display("test registers done");
    for (int t = 0; t < 6; t++) begin
      {s, d, g, m} = cfg[t];
      for (int i = 0; i < 6; i++) begin
        c = codes[i];
        w = m + ($random(seed) & 1);
        @(posedge mclk);
        mon <= 1'b0;
        @(posedge mclk);
        mon <= 1'b1;
        u_cpu.run(c, s, d, g, m, w);
        wr = (c == CODE_IO_WRITE) || (c == CODE_MEM_WRITE);
        act = (c != CODE_HALT);
        chk(32'(seen_cmd), (s && g && !d && act) ? 32'(exp_cmd(c)) : 32'h0,
            "command");
        chk(32'(seen_ten), 32'(act && g && (s || (!m && wr))),
            "enable");
        chk(32'(seen_rd), 32'(act && s && !wr), "dir");
        chk(32'(seen_ale), 32'(act), "latch");
        chk(32'(seen_cas), 32'(c == CODE_INTR_ACK), "cascade");
        chk(32'(seen_flt), 32'(m && !g), "float");
        chk(32'({cmd_out, t_en, t_dir}), 32'h1, "rest");
      end
      $display("test %0d done", t);
    end
    // software disable: a started cycle is ignored, outputs stay idle
    apb(1'b1, REG_CONTROL, 32'h0);
    apb(1'b0, REG_CONTROL, 32'h0);
    chk(rd, 32'h0, "control off");
    @(posedge mclk);
    mon <= 1'b0;
    @(posedge mclk);
    mon <= 1'b1;
    u_cpu.run(CODE_MEM_READ, 1'b1, 1'b0, 1'b1, 1'b0, 0);
    chk(32'({seen_cmd, seen_ten, seen_rd, seen_ale, seen_cas}), 32'h0,
        "disabled");
    chk(32'({cmd_out, t_en, t_dir}), 32'h1, "idle rest");
    $display("test disable done");
    complete_run();
  end
endmodule // bus_command_gating_control_tb_top
`default_nettype wire
